// file: hw/pxg_cfg.svh
// Register offsets, field positions, reset values and write mask of the port block
`ifndef PXG_CFG_SVH
`define PXG_CFG_SVH
`define PXG_ADDR_PORT0_LATCH      8'h80
`define PXG_ADDR_PORT1_LATCH      8'h90
`define PXG_ADDR_PORT0_DRIVE      8'hA4
`define PXG_ADDR_PORT1_DRIVE      8'hA5
`define PXG_ADDR_XBAR_SECOND      8'hE2
`define PXG_RST_LATCH             8'hFF
`define PXG_RST_DRIVE             8'h00
`define PXG_RST_XBAR              8'h00
`define PXG_XBAR_WRITE_MASK       8'hFB
`define PXG_BIT_WEAK_PULLUP_DIS   7
`define PXG_BIT_XBAR_ENABLE       6
`define PXG_BIT_TIMER1_PIN        5
`define PXG_BIT_TIMER0_PIN        4
`define PXG_BIT_EXT_CLOCK_PIN     3
`define PXG_FIELD_MODULE_HI       1
`define PXG_FIELD_MODULE_LO       0
`define PXG_BIT_ADDR_PORT0        4'h8
`define PXG_BIT_ADDR_PORT1        4'h9
`endif

// file: hw/pxg_pkg.sv
// Types shared by the port block files
package pxg_pkg;
  typedef enum logic [1:0] {
    PXG_MOD_NONE = 2'h0,
    PXG_MOD_0    = 2'h1,
    PXG_MOD_01   = 2'h2,
    PXG_MOD_012  = 2'h3
  } pxg_module_sel_t;
endpackage : pxg_pkg

// file: hw/pxg_pin_ctrl.sv
// Per-pin driver control for one 8-bit port
module pxg_pin_ctrl #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] out_value,
  input  wire logic [WIDTH-1:0] push_pull,
  input  wire logic [WIDTH-1:0] digital_mode,
  input  wire logic [WIDTH-1:0] bus_pin,
  input  wire logic             drivers_on,
  input  wire logic             pullup_dis,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic pp;
      // Analog pins ignore the drive mode; bus pins are forced open-drain
      assign pp = push_pull[g] & digital_mode[g] & ~bus_pin[g];
      assign pin_out[g] = out_value[g];
      // Open-drain only ever drives low
      assign pin_oe[g] = drivers_on & digital_mode[g] & (pp | ~out_value[g]);
      // Pull-up only on open-drain pins not driving low, never on analog
      assign pin_pullup[g] = ~pullup_dis & digital_mode[g] & ~pp
                             & ~(drivers_on & ~out_value[g]);
    end
  endgenerate
endmodule : pxg_pin_ctrl

// file: hw/pxg_port_io.sv
// Port I/O block: crossbar config, port latches, drive modes, pin control
// Notes on behaviour
// - Timer1 input reaches a pin only while its pin-enable bit is set.
// - Timer0 input reaches a pin only while its pin-enable bit is set.
// - Counter-array external clock reaches a pin only while its bit is set.
// - Module field 00 none, 01 module0, 10 modules 0-1, 11 modules 0-2.
// - Unassigned non-analog pins are general I/O driven by port latches.
// - Port latches are written as a byte or as single bits.
// - A write stores into the output latch, which drives until next write.
// - Ordinary port reads return pin levels, even for crossbar-assigned pins.
// - Read-modify-write on a port reads the latch, not the pins.
// - Latch read applies to logic, increment, bit and jump-clear instructions.
// - Drive-mode bit 0 selects open-drain, 1 push-pull; resets to zero.
// - Drive-mode bit is ignored on pins in analog input mode.
// - Pins carrying the management bus are always open-drain.
// - Pull-up disable 0 enables pull-ups on open-drain pins not driving low.
// - With crossbar disabled every pin is a plain port pin in input mode.
// - With crossbar disabled all port output drivers are off.
module pxg_port_io (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [7:0] sfr_bit_addr,
  input  wire logic       sfr_bit_wdata,
  input  wire logic       sfr_rmw,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_bit_rdata,
  input  wire logic [7:0] port0_pin_in,
  input  wire logic [7:0] port1_pin_in,
  output logic      [7:0] port0_pin_out,
  output logic      [7:0] port0_pin_oe,
  output logic      [7:0] port0_pin_pullup,
  output logic      [7:0] port1_pin_out,
  output logic      [7:0] port1_pin_oe,
  output logic      [7:0] port1_pin_pullup,
  input  wire logic [7:0] port0_input_mode,
  input  wire logic [7:0] port1_input_mode,
  input  wire logic [7:0] port0_periph_sel,
  input  wire logic [7:0] port1_periph_sel,
  input  wire logic [7:0] port0_periph_out,
  input  wire logic [7:0] port1_periph_out,
  input  wire logic [7:0] port0_bus_pin,
  input  wire logic [7:0] port1_bus_pin,
  output logic            crossbar_enable,
  output logic            timer1_pin_enable,
  output logic            timer0_pin_enable,
  output logic            array_ext_clock_pin_enable,
  output logic      [2:0] array_module_pin_enable
);
`include "pxg_cfg.svh"

  typedef struct packed {
    logic [7:0] port0_latch;
    logic [7:0] port1_latch;
    logic [7:0] port0_drive_mode;
    logic [7:0] port1_drive_mode;
    logic [7:0] crossbar_config_second;
    logic [7:0] port0_sync1;
    logic [7:0] port0_sync2;
    logic [7:0] port1_sync1;
    logic [7:0] port1_sync2;
    logic [7:0] rdata;
    logic       bit_rdata;
  } pxg_state_t;

  pxg_state_t state_reg;
  pxg_state_t state_next;
  logic [7:0] xcfg;
  logic [7:0] port0_src;
  logic [7:0] port1_src;
  logic [7:0] port0_digital;
  logic [7:0] port1_digital;
  logic [7:0] port0_bus_live;
  logic [7:0] port1_bus_live;
  logic [4:0] bit_page;
  logic       bit_hits_port0;
  logic       bit_hits_port1;
  logic       pullup_off;
  pxg_pkg::pxg_module_sel_t msel;

  assign xcfg = state_reg.crossbar_config_second;
  assign msel = pxg_pkg::pxg_module_sel_t'(xcfg[`PXG_FIELD_MODULE_HI:`PXG_FIELD_MODULE_LO]);
  assign pullup_off = xcfg[`PXG_BIT_WEAK_PULLUP_DIS];

  // Bit addresses share their upper five bits with the port's byte address
  assign bit_page       = sfr_bit_addr[7:3];
  assign bit_hits_port0 = bit_page == 5'(`PXG_ADDR_PORT0_LATCH >> 3);
  assign bit_hits_port1 = bit_page == 5'(`PXG_ADDR_PORT1_LATCH >> 3);

  always_comb begin
    logic [7:0] port0_view;
    logic [7:0] port1_view;
    logic [7:0] bsrc;
    port0_view = 8'h00;
    port1_view = 8'h00;
    bsrc = 8'h00;
    state_next = state_reg;
    // Pins are asynchronous to ref_clk, so only the second flop is ever read
    state_next.port0_sync1 = port0_pin_in;
    state_next.port0_sync2 = state_reg.port0_sync1;
    state_next.port1_sync1 = port1_pin_in;
    state_next.port1_sync2 = state_reg.port1_sync1;
    // Analog pins read back as zero: their digital receiver is off
    port0_view = state_reg.port0_sync2 & port0_input_mode;
    port1_view = state_reg.port1_sync2 & port1_input_mode;
    if (sfr_rmw) begin
      port0_view = state_reg.port0_latch;
      port1_view = state_reg.port1_latch;
    end
    // Reads are registered, so data stands one cycle after the address
    case (sfr_addr)
      `PXG_ADDR_PORT0_LATCH: state_next.rdata = port0_view;
      `PXG_ADDR_PORT1_LATCH: state_next.rdata = port1_view;
      `PXG_ADDR_PORT0_DRIVE: state_next.rdata = state_reg.port0_drive_mode;
      `PXG_ADDR_PORT1_DRIVE: state_next.rdata = state_reg.port1_drive_mode;
      `PXG_ADDR_XBAR_SECOND: state_next.rdata = xcfg;
      default:               state_next.rdata = 8'h00;
    endcase
    if (bit_hits_port0) begin
      bsrc = port0_view;
    end else if (bit_hits_port1) begin
      bsrc = port1_view;
    end
    state_next.bit_rdata = bsrc[sfr_bit_addr[2:0]];
    if (sfr_wr) begin
      case (sfr_addr)
        `PXG_ADDR_PORT0_LATCH: state_next.port0_latch = sfr_wdata;
        `PXG_ADDR_PORT1_LATCH: state_next.port1_latch = sfr_wdata;
        `PXG_ADDR_PORT0_DRIVE: state_next.port0_drive_mode = sfr_wdata;
        `PXG_ADDR_PORT1_DRIVE: state_next.port1_drive_mode = sfr_wdata;
        `PXG_ADDR_XBAR_SECOND:
          state_next.crossbar_config_second = sfr_wdata & `PXG_XBAR_WRITE_MASK;
        default: ;
      endcase
    end
    if (sfr_bit_wr) begin
      // Single-bit write leaves the other latch bits untouched; placed after
      // the byte write so it wins on its bit when both land in one cycle
      if (bit_hits_port0) begin
        state_next.port0_latch[sfr_bit_addr[2:0]] = sfr_bit_wdata;
      end else if (bit_hits_port1) begin
        state_next.port1_latch[sfr_bit_addr[2:0]] = sfr_bit_wdata;
      end
    end
  end

  // Synchronous reset; the sync flops clear too, so no stale level leaks out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.port0_latch <= `PXG_RST_LATCH;
      state_reg.port1_latch <= `PXG_RST_LATCH;
      state_reg.port0_drive_mode <= `PXG_RST_DRIVE;
      state_reg.port1_drive_mode <= `PXG_RST_DRIVE;
      state_reg.crossbar_config_second <= `PXG_RST_XBAR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata     = state_reg.rdata;
  assign sfr_bit_rdata = state_reg.bit_rdata;

  assign crossbar_enable = xcfg[`PXG_BIT_XBAR_ENABLE];
  // Peripheral routing only counts once the crossbar is on
  assign timer1_pin_enable = crossbar_enable & xcfg[`PXG_BIT_TIMER1_PIN];
  assign timer0_pin_enable = crossbar_enable & xcfg[`PXG_BIT_TIMER0_PIN];
  assign array_ext_clock_pin_enable = crossbar_enable & xcfg[`PXG_BIT_EXT_CLOCK_PIN];

  // Module routing is cumulative: each code adds one more module
  always_comb begin
    case (msel)
      pxg_pkg::PXG_MOD_NONE: array_module_pin_enable = 3'h0;
      pxg_pkg::PXG_MOD_0:    array_module_pin_enable = 3'h1;
      pxg_pkg::PXG_MOD_01:   array_module_pin_enable = 3'h3;
      pxg_pkg::PXG_MOD_012:  array_module_pin_enable = 3'h7;
      default:               array_module_pin_enable = 3'h0;
    endcase
    if (!crossbar_enable) begin
      array_module_pin_enable = 3'h0;
    end
  end

  // Crossbar-assigned pins take peripheral data, the rest the port latch
  assign port0_src = crossbar_enable ?
    ((port0_periph_sel & port0_periph_out) | (~port0_periph_sel & state_reg.port0_latch))
    : state_reg.port0_latch;
  assign port1_src = crossbar_enable ?
    ((port1_periph_sel & port1_periph_out) | (~port1_periph_sel & state_reg.port1_latch))
    : state_reg.port1_latch;
  assign port0_digital = port0_input_mode;
  assign port1_digital = port1_input_mode;

  // Bus pins only exist as such once the crossbar has routed them
  assign port0_bus_live = port0_bus_pin & {8{crossbar_enable}};
  assign port1_bus_live = port1_bus_pin & {8{crossbar_enable}};

  pxg_pin_ctrl #(.WIDTH(8)) u_port0 (
    .out_value    (port0_src),
    .push_pull    (state_reg.port0_drive_mode),
    .digital_mode (port0_digital),
    .bus_pin      (port0_bus_live),
    .drivers_on   (crossbar_enable),
    .pullup_dis   (pullup_off),
    .pin_out      (port0_pin_out),
    .pin_oe       (port0_pin_oe),
    .pin_pullup   (port0_pin_pullup)
  );

  pxg_pin_ctrl #(.WIDTH(8)) u_port1 (
    .out_value    (port1_src),
    .push_pull    (state_reg.port1_drive_mode),
    .digital_mode (port1_digital),
    .bus_pin      (port1_bus_live),
    .drivers_on   (crossbar_enable),
    .pullup_dis   (pullup_off),
    .pin_out      (port1_pin_out),
    .pin_oe       (port1_pin_oe),
    .pin_pullup   (port1_pin_pullup)
  );
endmodule : pxg_port_io

// file: bench/pxg_pins_model.sv
// Pad model for one port: resolves the level seen at each pin
module pxg_pins_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_low,
  output logic      [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] noise_reg = 8'h55;
  // A floating pad wanders, so a stale value never passes for a driven one
  always_ff @(posedge ref_clk) noise_reg <= ~noise_reg;
  assign level = ~(pin_oe & ~pin_out) & ~ext_low & (pin_oe | pin_pullup | noise_reg);
endmodule : pxg_pins_model

// file: bench/pxg_port_io_checker.sv
// Concurrent checks on the port block's port 0 pins, routing outputs and read data
module pxg_port_io_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_bit_wr,
  input wire logic       sfr_rmw,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_pin_out,
  input wire logic [7:0] port0_pin_oe,
  input wire logic [7:0] port0_pin_pullup,
  input wire logic [7:0] port0_input_mode,
  input wire logic [7:0] port0_periph_sel,
  input wire logic [7:0] port0_bus_pin,
  input wire logic       crossbar_enable,
  input wire logic       timer1_pin_enable,
  input wire logic       timer0_pin_enable,
  input wire logic [2:0] array_module_pin_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mod_exp;
  assign mod_exp = {&sfr_wdata[1:0], sfr_wdata[1], |sfr_wdata[1:0]} & {3{sfr_wdata[6]}};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence xbar_wr; sfr_wr && sfr_addr == 8'hE2; endsequence
  sequence port0_byte_wr; sfr_wr && !sfr_bit_wr && sfr_addr == 8'h80; endsequence
  drivers_off_a: assert property (!crossbar_enable |-> port0_pin_oe == 8'h00)
    else $error("driver on with crossbar off");
  t1_route_a: assert property (xbar_wr |=> timer1_pin_enable == (($past(sfr_wdata) & 8'h60) == 8'h60))
    else $error("timer1 routing wrong");
  t0_route_a: assert property (xbar_wr |=> timer0_pin_enable == (($past(sfr_wdata) & 8'h50) == 8'h50))
    else $error("timer0 routing wrong");
  module_route_a: assert property (xbar_wr |=> array_module_pin_enable == $past(mod_exp))
    else $error("module routing wrong");
  latch_drive_a: assert property (port0_byte_wr ##1 port0_periph_sel == 8'h00 |-> port0_pin_out == $past(sfr_wdata))
    else $error("latch not driving pins");
  rmw_latch_a: assert property (sfr_rmw && sfr_addr == 8'h80 && port0_periph_sel == 8'h00 |=> sfr_rdata == $past(port0_pin_out))
    else $error("rmw read not from latch");
  pullup_off_a: assert property (((port0_pin_pullup & ~port0_input_mode) | (port0_pin_pullup & port0_pin_oe & ~port0_pin_out)) == 8'h00)
    else $error("pull-up on where it must be off");
  bus_od_a: assert property ((port0_bus_pin & port0_pin_oe & port0_pin_out) == 8'h00)
    else $error("bus pin driven high");
endmodule : pxg_port_io_checker
bind pxg_port_io pxg_port_io_checker chk (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
  .sfr_bit_wr, .sfr_rmw, .sfr_rdata, .port0_pin_out, .port0_pin_oe, .port0_pin_pullup,
  .port0_input_mode, .port0_periph_sel, .port0_bus_pin, .crossbar_enable,
  .timer1_pin_enable, .timer0_pin_enable, .array_module_pin_enable);

// file: bench/pxg_port_io_tb.sv
// Self-checking bench for the port block
module pxg_port_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
  logic       sfr_bit_wdata = 1'b0, sfr_rmw = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, ext_low = 8'h00;
  logic [7:0] port0_input_mode = 8'hFF, port0_periph_sel = 8'h00, port0_periph_out = 8'h00;
  logic [7:0] port0_bus_pin = 8'h00, port1_input_mode = 8'hFF, port1_periph_sel = 8'h00;
  logic [7:0] port1_periph_out = 8'h00, port1_bus_pin = 8'h00;
  logic [7:0] sfr_rdata, port0_pin_in, port1_pin_in, port0_pin_out, port0_pin_oe;
  logic [7:0] port0_pin_pullup, port1_pin_out, port1_pin_oe, port1_pin_pullup;
  logic       sfr_bit_rdata, crossbar_enable, timer1_pin_enable, timer0_pin_enable;
  logic       array_ext_clock_pin_enable;
  logic [2:0] array_module_pin_enable;
  int         n_fail = 0, n_compared = 0;
  pxg_port_io dut (.*);
  pxg_pins_model pins0 (.ref_clk, .pin_out(port0_pin_out), .pin_oe(port0_pin_oe),
    .pin_pullup(port0_pin_pullup), .ext_low(8'h00), .level(port0_pin_in));
  pxg_pins_model pins1 (.ref_clk, .pin_out(port1_pin_out), .pin_oe(port1_pin_oe),
    .pin_pullup(port1_pin_pullup), .ext_low(ext_low), .level(port1_pin_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rmw <= m;
    @(posedge ref_clk);
    #1 chk(sfr_rdata, exp);
  endtask : rd
  function automatic logic [7:0] route();
    return {1'b0, crossbar_enable, timer1_pin_enable, timer0_pin_enable,
            array_ext_clock_pin_enable, array_module_pin_enable};
  endfunction : route
  task automatic t_reset();
    rd(8'h80, 1'b1, 8'hFF);
    rd(8'h90, 1'b1, 8'hFF);
    rd(8'hA4, 1'b0, 8'h00);
    rd(8'hA5, 1'b0, 8'h00);
    rd(8'hE2, 1'b0, 8'h00);
    rd(8'h33, 1'b0, 8'h00);
    chk(port0_pin_oe | port1_pin_oe, 8'h00);
    chk(port0_pin_pullup, 8'hFF);
  endtask : t_reset
  task automatic t_config();
    wr(8'hE2, 8'hFF);
    rd(8'hE2, 1'b0, 8'hFB);
    for (int c = 0; c < 4; c++) begin
      wr(8'hE2, 8'h40 | 8'(c));
      #1 chk(route(), 8'h40 | 8'((1 << c) - 1));
    end
    wr(8'hE2, 8'h7B);
    #1 chk(route(), 8'h7F);
    wr(8'hE2, 8'h6A);
    #1 chk(route(), 8'h6B);
    wr(8'hE2, 8'h3B);
    #1 chk(route(), 8'h00);
  endtask : t_config
  task automatic t_latch();
    @(posedge ref_clk);
    port0_input_mode <= 8'hFE;
    port0_bus_pin <= 8'h02;
    wr(8'hA4, 8'h0F);
    wr(8'h80, 8'h5A);
    #1 chk(port0_pin_oe, 8'h00);
    wr(8'hE2, 8'h40);
    #1 chk(port0_pin_out, 8'h5A);
    chk(port0_pin_oe, 8'hAC);
    chk(port0_pin_pullup & 8'hFD, 8'h50);
    wr(8'hE2, 8'hC0);
    #1 chk(port0_pin_pullup, 8'h00);
    @(posedge ref_clk);
    port0_periph_sel <= 8'h80;
    port0_periph_out <= 8'h80;
    @(posedge ref_clk);
    #1 chk(port0_pin_out, 8'hDA);
  endtask : t_latch
  task automatic t_pins();
    wr(8'hE2, 8'h40);
    sfr_bit_addr <= 8'h93;
    sfr_bit_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_bit_wr <= 1'b0;
    ext_low <= 8'h01;
    #1 chk(port1_pin_out, 8'hF7);
    chk(port1_pin_pullup, 8'hF7);
    repeat (3) @(posedge ref_clk);
    rd(8'h90, 1'b0, 8'hF6);
    rd(8'h90, 1'b1, 8'hF7);
    @(posedge ref_clk);
    sfr_bit_addr <= 8'h90;
    sfr_rmw <= 1'b1;
    @(posedge ref_clk);
    #1 chk({7'h00, sfr_bit_rdata}, 8'h01);
    @(posedge ref_clk);
    sfr_rmw <= 1'b0;
    @(posedge ref_clk);
    #1 chk({7'h00, sfr_bit_rdata}, 8'h00);
  endtask : t_pins
  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Whole run is about 67 cycles; this leaves ample slack
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_latch();
    t_pins();
    wrap_up();
  end
endmodule : pxg_port_io_tb
